// File: stc_regs.svh
// constants and register map of the stepper translator and chopper control
// Behaviour
// - grounded off-time pin: always mixed decay
// - grounded off-time pin: 30 us off-time
// - supply-tied pin: 30 us, auto, full-step slow
// - resistor: off-time R/825 us, auto decay
// - reset low: home translator, outputs off
// - step edges ignored while reset low
// - step rising edge advances one increment
// - direction applied only at next step edge
// - drive diagonal until trip, then off-time
// - trip level is table percent of full scale
// - comparator blanked 1 us after switching
// - short to ground latches bridge off
// - shorted load repeats off-time cycles
// - enable high turns all outputs off
// - translator runs regardless of enable
// - regulator fault disables all outputs
// - overtemp or pump undervoltage disables outputs
// - supply lockout: outputs off, translator home
// - sleep low shuts down, startup at home
// - mixed: fast 31.25% then slow
// - rectify during decay, stop near zero
// - resolution select decode of five modes
// - falling level mixed, else slow decay
// - resolution applied only at next step edge
// - home is 45 degrees, equal currents
`ifndef STC_REGS_SVH
`define STC_REGS_SVH

`define STC_CLK_MHZ       25
`define STC_TOFF_FIXED_US 30
`define STC_TOFF_FIXED_CYC (`STC_TOFF_FIXED_US * `STC_CLK_MHZ)
`define STC_OFFTIME_CONFIG_PIN_DIV      825
`define STC_BLANK_US      1
`define STC_BLANK_CYC     (`STC_BLANK_US * `STC_CLK_MHZ)
`define STC_FAST_NUM      5
`define STC_FAST_SHIFT    4
`define STC_HOME_POS      6'h08

`define STC_ADDR_CFG      12'h000
`define STC_ADDR_OFFTIME_CONFIG_PIN     12'h004
`define STC_ADDR_STATUS   12'h008
`define STC_ADDR_DAC      12'h00C

`define STC_CFG_RESET     2'h0
`define STC_OFFTIME_CONFIG_PIN_RESET    20'h14238
`endif

// File: stc_pkg.sv
// types of the stepper translator and chopper control
package stc_pkg;
  typedef enum logic [1:0] {STC_TOFF_VDD, STC_TOFF_GND, STC_TOFF_RES, STC_TOFF_RSV} stc_toff_t;
  typedef enum logic [2:0] {STC_RES_FULL, STC_RES_HALF, STC_RES_QUARTER, STC_RES_EIGHTH, STC_RES_SIXTEENTH} stc_res_t;
  typedef enum {STC_CH_OFF, STC_CH_BLANK, STC_CH_ON, STC_CH_FAST, STC_CH_SLOW} stc_chop_t;
endpackage

// File: stc_core.sv
// stepper translator, fixed off-time choppers and protection with an APB slave
//
// Chosen here: the register addresses and register access over APB.
`timescale 1ns/1ps
`include "stc_regs.svh"
module stc_core
  import stc_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  input  wire logic        step,
  input  wire logic        dir,
  input  wire logic        resolution_select_bit0,
  input  wire logic        resolution_select_bit1,
  input  wire logic        resolution_select_bit2,
  input  wire logic        reset_n,
  input  wire logic        enable,
  input  wire logic        sleep_n,
  input  wire logic [1:0]  trip,
  input  wire logic [1:0]  short_gnd,
  input  wire logic [1:0]  zero_current,
  input  wire logic        sink_gate_regulator_fault,
  input  wire logic        overtemp,
  input  wire logic        pump_supply_low,
  input  wire logic        supply_lockout,
  output logic [13:0]      dac1,
  output logic [13:0]      dac2,
  output logic             pol1,
  output logic             pol2,
  output logic [3:0]       gate1,
  output logic [3:0]       gate2,
  output logic [1:0]       mixed_decay,
  output logic             pump_on
);

  localparam int NSYNC = 18;

  logic [NSYNC-1:0] pin_raw;
  logic [NSYNC-1:0] sync1;
  logic [NSYNC-1:0] sync2;
  logic [NSYNC-1:0] sync3;
  logic [NSYNC-1:0] pin_q;
  logic             step_d;
  logic             sleep_d;
  logic             step_rise;
  logic             sleep_rise;
  logic [5:0]       pos;
  logic [5:0]       next_pos;
  logic [5:0]       inc;
  stc_res_t         res_sel;
  stc_res_t         res_q;
  logic             home;
  logic             off_all;
  logic [13:0]      next_dac1;
  logic [13:0]      next_dac2;
  logic             next_pol1;
  logic             next_pol2;
  logic [1:0]       mixed_sel;
  logic [1:0]       short_latch;
  logic [1:0]       cfg_mode;
  logic [19:0]      offtime_config_pin_ohms;
  logic [15:0]      toff_cyc;
  logic [15:0]      fast_cyc;
  logic [24:0]      res_cyc;
  logic [31:0]      rd_mux;
  logic             apb_hit;
  logic [1:0]       trip_q;
  logic [1:0]       shortg_q;
  logic [1:0]       zero_q;
  logic [1:0]       mixed_eff;
  logic [3:0]       gate_q [2];
  logic             pol_q [2];

  // quarter-wave sine magnitude in hundredths of a percent
  function automatic logic [13:0] stc_mag(input logic [4:0] k);
    case (k)
      5'h00: stc_mag = 14'h0000;
      5'h01: stc_mag = 14'h03D4;
      5'h02: stc_mag = 14'h079F;
      5'h03: stc_mag = 14'h0B57;
      5'h04: stc_mag = 14'h0EF3;
      5'h05: stc_mag = 14'h126A;
      5'h06: stc_mag = 14'h15B4;
      5'h07: stc_mag = 14'h18C8;
      5'h08: stc_mag = 14'h1B9F;
      5'h09: stc_mag = 14'h1E32;
      5'h0A: stc_mag = 14'h207B;
      5'h0B: stc_mag = 14'h2273;
      5'h0C: stc_mag = 14'h2417;
      5'h0D: stc_mag = 14'h2561;
      5'h0E: stc_mag = 14'h2650;
      5'h0F: stc_mag = 14'h26E0;
      default: stc_mag = 14'h2710;
    endcase
  endfunction

  assign pin_raw = {supply_lockout, pump_supply_low, overtemp, sink_gate_regulator_fault, zero_current,
                    short_gnd, trip, sleep_n, enable, reset_n, resolution_select_bit2,
                    resolution_select_bit1, resolution_select_bit0, dir, step};

  genvar gi;
  generate
    for (gi = 0; gi < NSYNC; gi++)
    begin : g_sync
      always_ff @(posedge clk)
      begin
        if (sys_rst)
        begin
          sync1[gi] <= 1'b0;
          sync2[gi] <= 1'b0;
          sync3[gi] <= 1'b0;
          pin_q[gi] <= 1'b0;
        end
        else
        begin
          sync1[gi] <= pin_raw[gi];
          sync2[gi] <= sync1[gi];
          sync3[gi] <= sync2[gi];
          if (sync2[gi] == sync3[gi])
            pin_q[gi] <= sync3[gi];
        end
      end
    end
  endgenerate

  assign trip_q   = pin_q[9:8];
  assign shortg_q = pin_q[11:10];
  assign zero_q   = pin_q[13:12];

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      step_d  <= 1'b0;
      sleep_d <= 1'b0;
    end
    else
    begin
      step_d  <= pin_q[0];
      sleep_d <= pin_q[7];
    end
  end

  assign step_rise  = pin_q[0] & ~step_d;
  assign sleep_rise = pin_q[7] & ~sleep_d;

  assign home = ~pin_q[5] | pin_q[17] | ~pin_q[7];

  assign off_all = home | pin_q[6] | pin_q[14] | pin_q[15] | pin_q[16];
  assign pump_on = pin_q[7];

  always_comb
  begin
    case (pin_q[4:2])
      3'h0: res_sel = STC_RES_FULL;
      3'h1: res_sel = STC_RES_HALF;
      3'h2: res_sel = STC_RES_QUARTER;
      3'h3: res_sel = STC_RES_EIGHTH;
      default: res_sel = STC_RES_SIXTEENTH;
    endcase
  end

  always_comb
  begin
    case (res_sel)
      STC_RES_FULL:    inc = 6'h10;
      STC_RES_HALF:    inc = 6'h08;
      STC_RES_QUARTER: inc = 6'h04;
      STC_RES_EIGHTH:  inc = 6'h02;
      default:         inc = 6'h01;
    endcase
  end

  // direction sampled only with the step edge
  assign next_pos = pin_q[1] ? pos + inc : pos - inc;

  always_comb
  begin
    case (next_pos[5:4])
      2'h0:
      begin
        next_dac1 = stc_mag(5'h10 - {1'b0, next_pos[3:0]});
        next_dac2 = stc_mag({1'b0, next_pos[3:0]});
        next_pol1 = 1'b1;
        next_pol2 = 1'b1;
      end
      2'h1:
      begin
        next_dac1 = stc_mag({1'b0, next_pos[3:0]});
        next_dac2 = stc_mag(5'h10 - {1'b0, next_pos[3:0]});
        next_pol1 = 1'b0;
        next_pol2 = 1'b1;
      end
      2'h2:
      begin
        next_dac1 = stc_mag(5'h10 - {1'b0, next_pos[3:0]});
        next_dac2 = stc_mag({1'b0, next_pos[3:0]});
        next_pol1 = 1'b0;
        next_pol2 = 1'b0;
      end
      default:
      begin
        next_dac1 = stc_mag({1'b0, next_pos[3:0]});
        next_dac2 = stc_mag(5'h10 - {1'b0, next_pos[3:0]});
        next_pol1 = 1'b1;
        next_pol2 = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst || home)
    begin
      // home at 45 degrees, equal currents
      pos       <= `STC_HOME_POS;
      dac1      <= 14'h1B9F;
      dac2      <= 14'h1B9F;
      pol1      <= 1'b1;
      pol2      <= 1'b1;
      mixed_sel <= 2'h3;
      res_q     <= STC_RES_SIXTEENTH;
    end
    else if (step_rise)
    begin
      pos       <= next_pos;
      dac1      <= next_dac1;
      dac2      <= next_dac2;
      pol1      <= next_pol1;
      pol2      <= next_pol2;
      res_q     <= res_sel;
      mixed_sel <= {next_dac2 < dac2, next_dac1 < dac1};
    end
  end

  assign res_cyc  = (25'(offtime_config_pin_ohms) * 25'(`STC_CLK_MHZ)) / 25'(`STC_OFFTIME_CONFIG_PIN_DIV);
  always_comb
  begin
    if (cfg_mode == STC_TOFF_RES)
      toff_cyc = (res_cyc[24:16] != 9'h000) ? 16'hFFFF : ((res_cyc[15:0] == 16'h0000) ? 16'h0001 : res_cyc[15:0]);
    else
      toff_cyc = 16'(`STC_TOFF_FIXED_CYC);
  end
  assign fast_cyc = 16'((20'(toff_cyc) * 20'(`STC_FAST_NUM)) >> `STC_FAST_SHIFT);

  always_comb
  begin
    if (cfg_mode == STC_TOFF_GND)
      mixed_eff = 2'h3;
    else if (res_q == STC_RES_FULL)
      mixed_eff = 2'h0;
    else
      mixed_eff = mixed_sel;
  end
  assign mixed_decay = mixed_eff;

  generate
    for (gi = 0; gi < 2; gi++)
    begin : g_bridge
      stc_chop_t   st;
      logic [15:0] tmr;
      logic        rect_off;
      logic [3:0]  next_gate;

      // short latch, set wins over sleep exit
      always_ff @(posedge clk)
      begin
        if (sys_rst)
          short_latch[gi] <= 1'b0;
        else if (shortg_q[gi])
          short_latch[gi] <= 1'b1;
        else if (sleep_rise)
          short_latch[gi] <= 1'b0;
      end

      always_ff @(posedge clk)
      begin
        if (sys_rst || off_all || short_latch[gi])
        begin
          st  <= STC_CH_OFF;
          tmr <= 16'h0000;
        end
        else
        begin
          case (st)
            STC_CH_OFF:
            begin
              st  <= STC_CH_BLANK;
              tmr <= 16'(`STC_BLANK_CYC - 1);
            end
            STC_CH_BLANK:
            begin
              if (tmr == 16'h0000)
                st <= STC_CH_ON;
              else
                tmr <= tmr - 16'h0001;
            end
            STC_CH_ON:
            begin
              if (trip_q[gi])
              begin
                if (mixed_eff[gi] && fast_cyc != 16'h0000)
                begin
                  st  <= STC_CH_FAST;
                  tmr <= fast_cyc - 16'h0001;
                end
                else
                begin
                  st  <= STC_CH_SLOW;
                  tmr <= toff_cyc - 16'h0001;
                end
              end
            end
            STC_CH_FAST:
            begin
              if (tmr == 16'h0000)
              begin
                st  <= STC_CH_SLOW;
                tmr <= toff_cyc - fast_cyc - 16'h0001;
              end
              else
                tmr <= tmr - 16'h0001;
            end
            STC_CH_SLOW:
            begin
              if (tmr == 16'h0000)
              begin
                st  <= STC_CH_BLANK;
                tmr <= 16'(`STC_BLANK_CYC - 1);
              end
              else
                tmr <= tmr - 16'h0001;
            end
            default:
            begin
              st  <= STC_CH_OFF;
              tmr <= 16'h0000;
            end
          endcase
        end
      end

      always_ff @(posedge clk)
      begin
        if (sys_rst || (st != STC_CH_FAST && st != STC_CH_SLOW))
          rect_off <= 1'b0;
        else if (zero_q[gi])
          rect_off <= 1'b1;
      end

      assign pol_q[gi] = (gi == 0) ? pol1 : pol2;

      // gate order: source A, source B, sink A, sink B
      always_comb
      begin
        case (st)
          STC_CH_BLANK,
          STC_CH_ON:   next_gate = pol_q[gi] ? 4'h9 : 4'h6;
          STC_CH_FAST: next_gate = (rect_off || zero_q[gi]) ? 4'h0 : (pol_q[gi] ? 4'h6 : 4'h9);
          STC_CH_SLOW: next_gate = (rect_off || zero_q[gi]) ? 4'h0 : 4'h3;
          default:     next_gate = 4'h0;
        endcase
      end

      always_ff @(posedge clk)
      begin
        if (sys_rst || off_all || short_latch[gi])
          gate_q[gi] <= 4'h0;
        else
          gate_q[gi] <= next_gate;
      end
    end
  endgenerate

  assign gate1 = gate_q[0];
  assign gate2 = gate_q[1];

  // APB slave, zero wait states
  assign pready  = 1'b1;
  assign apb_hit = (paddr == `STC_ADDR_CFG) || (paddr == `STC_ADDR_OFFTIME_CONFIG_PIN) ||
                   (paddr == `STC_ADDR_STATUS) || (paddr == `STC_ADDR_DAC);
  assign pslverr = psel & penable & ~apb_hit;

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      cfg_mode  <= `STC_CFG_RESET;
      offtime_config_pin_ohms <= `STC_OFFTIME_CONFIG_PIN_RESET;
    end
    else if (psel && penable && pwrite)
    begin
      if (paddr == `STC_ADDR_CFG)
        cfg_mode <= pwdata[1:0];
      if (paddr == `STC_ADDR_OFFTIME_CONFIG_PIN)
        offtime_config_pin_ohms <= pwdata[19:0];
    end
  end

  always_comb
  begin
    case (paddr)
      `STC_ADDR_CFG:    rd_mux = {30'h0, cfg_mode};
      `STC_ADDR_OFFTIME_CONFIG_PIN:   rd_mux = {12'h0, offtime_config_pin_ohms};
      `STC_ADDR_STATUS: rd_mux = {toff_cyc, 3'h0, home, off_all, short_latch, mixed_eff, 1'b0, pos};
      `STC_ADDR_DAC:    rd_mux = {pol2, 1'b0, dac2, pol1, 1'b0, dac1};
      default:          rd_mux = 32'h0;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
      prdata <= 32'h0;
    else if (psel && !penable)
      prdata <= rd_mux;
  end

endmodule

// File: stc_core_sva.sv
// port assertions of the stepper translator and chopper core
`timescale 1ns/1ps
module stc_core_sva (
  input wire logic        clk,
  input wire logic        sys_rst,
  input wire logic        step,
  input wire logic        reset_n,
  input wire logic        enable,
  input wire logic        sleep_n,
  input wire logic [1:0]  short_gnd,
  input wire logic [1:0]  zero_current,
  input wire logic        sink_gate_regulator_fault,
  input wire logic        overtemp,
  input wire logic        pump_supply_low,
  input wire logic        supply_lockout,
  input wire logic [13:0] dac1,
  input wire logic [13:0] dac2,
  input wire logic        pol1,
  input wire logic        pol2,
  input wire logic [3:0]  gate1,
  input wire logic [3:0]  gate2,
  input wire logic        pump_on
);
  logic [3:0] drv;
  logic [3:0] rev;
  logic [9:0] on_cnt;
  logic       off;
  logic       home;
  logic       calm;
  assign drv = pol1 ? 4'h9 : 4'h6;
  assign rev = pol1 ? 4'h6 : 4'h9;
  assign off = gate1 == 4'h0 && gate2 == 4'h0;
  assign home = dac1 == 14'h1B9F && dac2 == 14'h1B9F;
  assign calm = !step && reset_n && sleep_n && !supply_lockout;
  // length of the current drive run of bridge 1
  always_ff @(posedge clk)
    if (sys_rst || gate1 != drv)
      on_cnt <= 10'h000;
    else if (on_cnt != 10'h3FF)
      on_cnt <= on_cnt + 10'h001;
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  property p_en; enable [*7] |-> off; endproperty
  a_en: assert property (p_en) else $error("outputs on while disabled");
  property p_rst; !reset_n [*7] |-> off && home && pol1 && pol2; endproperty
  a_rst: assert property (p_rst) else $error("reset low not home");
  property p_slp; !sleep_n [*7] |-> off && home && !pump_on; endproperty
  a_slp: assert property (p_slp) else $error("sleep not shut down");
  property p_lock; supply_lockout [*7] |-> off && home; endproperty
  a_lock: assert property (p_lock) else $error("lockout not home");
  property p_reg; sink_gate_regulator_fault [*7] |-> off; endproperty
  a_reg: assert property (p_reg) else $error("regulator fault ignored");
  property p_hot; (overtemp || pump_supply_low) [*7] |-> off; endproperty
  a_hot: assert property (p_hot) else $error("shutdown fault ignored");
  property p_sg; short_gnd[1] [*7] |-> gate2 == 4'h0; endproperty
  a_sg: assert property (p_sg) else $error("shorted bridge driven");
  property p_zc; zero_current[0] [*7] |-> gate1 != 4'h3 && gate1 != rev; endproperty
  a_zc: assert property (p_zc) else $error("rectifying at zero current");
  property p_still; calm [*8] |-> $stable(dac1) && $stable(dac2) && $stable(pol1) && $stable(pol2); endproperty
  a_still: assert property (p_still) else $error("levels moved without step");
  property p_blank;
    ($past(gate1) == drv && $past(pol1, 2) == pol1 && (gate1 == rev || gate1 == 4'h3)) |-> on_cnt >= 10'h019;
  endproperty
  a_blank: assert property (p_blank) else $error("trip taken in blanking");
  property p_fast; ($past(gate1) == rev && $past(pol1, 2) == pol1 && gate1 != rev) |-> gate1 inside {4'h3, 4'h0}; endproperty
  a_fast: assert property (p_fast) else $error("fast decay not followed by slow");
  c_decay: cover property (gate1 == rev ##1 gate1 == 4'h3);
  c_step: cover property ($rose(step));
  c_short: cover property (short_gnd[1] [*7]);
endmodule
bind stc_core stc_core_sva i_sva (.clk, .sys_rst, .step, .reset_n, .enable, .sleep_n, .short_gnd, .zero_current,
  .sink_gate_regulator_fault, .overtemp, .pump_supply_low, .supply_lockout, .dac1, .dac2, .pol1, .pol2,
  .gate1, .gate2, .pump_on);

// File: stc_ctrl_model.sv
// controller model that issues one step pulse per request
`timescale 1ns/1ps
module stc_ctrl_model #(
  parameter int WAIT_CYC = 25000
) (
  input  wire logic clk,
  input  wire logic sys_rst,
  input  wire logic sleep_n,
  input  wire logic go,
  output logic      busy,
  output logic      step
);
  int   hold;
  int   cnt;
  logic slp_q;
  logic bz;
  logic hi;
  assign busy = bz === 1'b1;
  assign step = hi === 1'b1;
  always_ff @(posedge clk)
  begin
    slp_q <= sleep_n;
    if (sys_rst || (sleep_n && !slp_q))
      hold <= WAIT_CYC;
    else if (hold != 0)
      hold <= hold - 1;
    if (sys_rst)
      bz <= 1'b0;
    else if (go && !busy)
      bz <= 1'b1;
    else if (busy && hold == 0 && cnt == 12)
      bz <= 1'b0;
    cnt <= (busy && hold == 0) ? cnt + 1 : 0;
    // six cycles high, seven low
    hi <= busy && hold == 0 && cnt < 6;
  end
endmodule

// File: tb_top.sv
// bench of the stepper core against a behavioural translator model
`timescale 1ns/1ps
module tb_top;
  logic        clk = 1'b0, sys_rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic        pready, pslverr, err, step, busy, go = 1'b0, dir = 1'b1, reset_n = 1'b0, sleep_n = 1'b1;
  logic [2:0]  res = 3'h7;
  logic [4:0]  flt = 5'h0;
  logic [1:0]  trip = 2'h0, short_gnd = 2'h0, zero_current = 2'h0, mixed_decay;
  logic [13:0] dac1, dac2;
  logic        pol1, pol2, pump_on;
  logic [3:0]  gate1, gate2;
  int          mismatches = 0, samples_checked = 0, cycles = 0, pos = 8, cfg = 0, n;
  int          tab[17] = '{10000, 9952, 9808, 9569, 9239, 8819, 8315, 7730, 7071, 6344, 5556, 4714, 3827, 2903,
                           1951, 980, 0};
  int          inc[$] = '{16, 8, 4, 2, 1, 1, 1, 1};
  stc_core i_dut (.clk, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr, .step,
    .dir, .resolution_select_bit0(res[0]), .resolution_select_bit1(res[1]), .resolution_select_bit2(res[2]),
    .reset_n, .enable(flt[4]), .sleep_n, .trip, .short_gnd, .zero_current, .sink_gate_regulator_fault(flt[3]),
    .overtemp(flt[2]), .pump_supply_low(flt[1]), .supply_lockout(flt[0]), .dac1, .dac2, .pol1, .pol2, .gate1,
    .gate2, .mixed_decay, .pump_on);
  stc_ctrl_model i_ctrl (.clk, .sys_rst, .sleep_n, .go, .busy, .step);
  always #20 clk = ~clk;
  task automatic conclude;
    if (mismatches == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 95000)
    begin
      mismatches++;
      conclude();
    end
  end
  function automatic int lvl(input int p);
    return (p % 32 <= 16) ? tab[p % 32] : tab[32 - p % 32];
  endfunction
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      mismatches++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic idle;
    while (busy !== 1'b0) @(posedge clk);
    repeat (2) @(posedge clk);
  endtask
  task automatic pulse;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    while (step !== 1'b1) @(posedge clk);
  endtask
  task automatic run(input logic [3:0] v);
    while (gate1 !== v) @(posedge clk);
    for (n = 0; gate1 === v; n++) @(posedge clk);
  endtask
  task automatic do_step(input logic [2:0] code, input logic d);
    int o1, o2, n1, n2;
    o1 = lvl(pos);
    o2 = lvl((pos + 48) % 64);
    res <= code;
    dir <= d;
    flt <= {1'($urandom), 4'h0};
    pulse();
    repeat (6) @(posedge clk);
    // late pin changes belong to the following step
    res <= 3'($urandom);
    dir <= ~d;
    idle();
    pos = (pos + (d ? inc[code] : 64 - inc[code])) % 64;
    n1 = lvl(pos);
    n2 = lvl((pos + 48) % 64);
    cmp(dac1, n1);
    cmp(dac2, n2);
    if (n1 != 0) cmp(pol1, pos < 16 || pos > 48);
    if (n2 != 0) cmp(pol2, pos > 0 && pos < 32);
    cmp(mixed_decay, cfg == 1 ? 3 : code == 0 ? 0 : {n2 < o2, n1 < o1});
  endtask
  initial
  begin
    void'($urandom(52554));
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    apb(0, 12'h000, 0);
    cmp(rd, 0);
    apb(0, 12'h004, 0);
    cmp(rd, 32'h00014238);
    apb(0, 12'h008, 0);
    cmp(rd[31:16], 750);
    apb(0, 12'h00C, 0);
    cmp(rd, 32'h9B9F9B9F);
    apb(0, 12'h010, 0);
    cmp({err, rd[30:0]}, 32'h80000000);
    reset_n <= 1'b1;
    repeat (40) @(posedge clk);
    cmp(gate1, 4'h9);
    trip <= 2'h1;
    run(4'h6);
    cmp(n, 234);
    run(4'h3);
    cmp(n, 516);
    run(4'h9);
    cmp(n >= 25 && n <= 27, 1);
    apb(1, 12'h004, 16500);
    apb(1, 12'h000, 2);
    apb(0, 12'h008, 0);
    cmp(rd[31:16], 500);
    run(4'h3);
    run(4'h6);
    cmp(n, 156);
    run(4'h3);
    cmp(n, 344);
    apb(1, 12'h000, 1);
    apb(0, 12'h008, 0);
    cmp(rd[31:16], 750);
    cmp(mixed_decay, 3);
    while (gate1 !== 4'h3) @(posedge clk);
    zero_current <= 2'h1;
    repeat (8) @(posedge clk);
    cmp(gate1, 0);
    zero_current <= 2'h0;
    trip <= 2'h0;
    repeat (800) @(posedge clk);
    short_gnd <= 2'h2;
    repeat (8) @(posedge clk);
    short_gnd <= 2'h0;
    repeat (40) @(posedge clk);
    cmp({gate1, gate2}, 8'h90);
    sleep_n <= 1'b0;
    repeat (8) @(posedge clk);
    cmp(pump_on, 0);
    sleep_n <= 1'b1;
    repeat (40) @(posedge clk);
    cmp(gate2, 4'h9);
    apb(1, 12'h000, 0);
    for (int i = 0; i < 32; i++)
    begin
      if (i == 24)
      begin
        apb(1, 12'h000, 1);
        cfg = 1;
      end
      do_step(i < 8 ? 3'(i) : 3'($urandom), 1'($urandom));
    end
    for (int i = 0; i < 5; i++)
    begin
      flt <= 5'h1 << i;
      repeat (8) @(posedge clk);
      cmp({gate1, gate2}, 0);
      flt <= 5'h0;
      repeat (40) @(posedge clk);
    end
    pos = 8;
    cmp(dac1, 7071);
    do_step(3'h7, 1'b1);
    apb(1, 12'h000, 0);
    cfg = 0;
    reset_n <= 1'b0;
    pulse();
    idle();
    cmp({dac1, dac2}, {14'h1B9F, 14'h1B9F});
    reset_n <= 1'b1;
    pos = 8;
    repeat (8) @(posedge clk);
    cmp(mixed_decay, 3);
    do_step(3'h7, 1'b1);
    conclude();
  end
endmodule
